// file: include/pbk_regs.svh
// register offsets, field positions and reset values of the port block
`ifndef PBK_REGS_SVH
`define PBK_REGS_SVH

// register offsets (byte address on the register port)
`define PBK_ADDR_DATA        4'h0
`define PBK_ADDR_DIR         4'h1
`define PBK_ADDR_PULL        4'h2
`define PBK_ADDR_SLEW        4'h3
`define PBK_ADDR_DRIVE       4'h4
`define PBK_ADDR_STSCTL      4'h5
`define PBK_ADDR_SRCSEL      4'h6
`define PBK_ADDR_POLSEL      4'h7
`define PBK_ADDR_IRQ_STS     4'h8
`define PBK_ADDR_IRQ_CLR     4'h9
`define PBK_ADDR_IRQ_EN      4'hA

// fields of the pin interrupt status and control register
`define PBK_SC_FLAG_BIT      3
`define PBK_SC_ACK_BIT       2
`define PBK_SC_IE_BIT        1
`define PBK_SC_MODE_BIT      0

// fields of the block interrupt status, clear and enable registers
`define PBK_IRQ_FLAG_SET_BIT 0
`define PBK_IRQ_WIDTH        1

// reset values
`define PBK_RST_DATA         8'h00
`define PBK_RST_DIR          8'h00
`define PBK_RST_PULL         8'h00
`define PBK_RST_SLEW         8'h00
`define PBK_RST_DRIVE        8'h00
`define PBK_RST_SRCSEL       8'h00
`define PBK_RST_POLSEL       8'h00
`define PBK_RST_BYTE         8'h00

`endif

// file: include/pbk_pkg.sv
// types shared by the port block
package pbk_pkg;

   // register port address
   typedef logic [3:0] pbk_addr_t;

   // register port data
   typedef logic [7:0] pbk_byte_t;

   // pin interrupt detection mode
   typedef enum logic [0:0] {
      PBK_MODE_EDGE       = 1'b0,
      PBK_MODE_EDGE_LEVEL = 1'b1
   } pbk_mode_t;

endpackage : pbk_pkg

// file: core/pbk_port.sv
// eight-bit port with pin control and pin interrupt unit
//
// Summary of operation
// R1: slew bit limits slew on output pins only
// R2: software rewrites slew setting after every reset
// R3: drive bit selects low or high drive
// R4: flag reads one after qualifying pin event
// R5: software writes never set the flag
// R6: writing one to acknowledge clears the flag
// R7: acknowledge bit always reads as zero
// R8: enable bit gates the port interrupt request
// R9: mode bit picks edges only or edges+levels
// R10: source select bit makes pin an interrupt source
// R11: polarity zero: falling/low sense, pull-up device
// R12: polarity one: rising/high sense, pull-down device
// R13: polarity bit sets both sense and pull
// R14: data read gives pin or latch per direction
// R15: direction bit enables the output driver
// R16: reset clears latch, pins input, pulls off
// R17: pull enable ignored on output pins
// R18: request asserted while flag and enable set
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pbk_regs.svh"

module pbk_port #(
   parameter int PINS = 8
) (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // register port
   input  wire pbk_pkg::pbk_addr_t reg_addr,
   input  wire pbk_pkg::pbk_byte_t reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [7:0]             reg_rdata,
   // pins
   input  wire logic [PINS-1:0]   pin_in,
   output logic [PINS-1:0]        pin_out,
   output logic [PINS-1:0]        pin_oe,
   output logic [PINS-1:0]        pull_up_en,
   output logic [PINS-1:0]        pull_down_en,
   output logic [PINS-1:0]        slew_limit_on,
   output logic [PINS-1:0]        drive_high_on,
   // interrupts
   output logic                   pin_irq_req,
   output logic                   irq
);

   // *****************************************************************
   // elaboration check
   // *****************************************************************
   // the register port carries one byte, so no more than eight pins
   if (PINS < 1 || PINS > 8) begin : g_bad_pins
      $error("pbk_port: PINS must lie between 1 and 8");
   end

   // *****************************************************************
   // declarations
   // *****************************************************************
   logic [PINS-1:0]            port_data_latch_ff;
   logic [PINS-1:0]            port_direction_ff;
   logic [PINS-1:0]            pull_device_enable_ff;
   logic [PINS-1:0]            slew_limit_enable_ff;
   logic [PINS-1:0]            drive_strength_select_ff;
   logic [PINS-1:0]            pin_irq_source_select_ff;
   logic [PINS-1:0]            pin_irq_polarity_select_ff;
   logic                       pin_irq_flag_ff;
   logic                       pin_irq_request_enable_ff;
   pbk_pkg::pbk_mode_t         detect_mode_select_ff;
   logic [PINS-1:0]            active_prev_ff;
   logic [`PBK_IRQ_WIDTH-1:0]  irq_sts_ff;
   logic [`PBK_IRQ_WIDTH-1:0]  irq_en_ff;
   logic [7:0]                 reg_rdata_ff;

   logic [PINS-1:0]            pin_active;
   logic [PINS-1:0]            pin_edge;
   logic [PINS-1:0]            pin_hit;
   logic                       pin_event;
   logic                       ack_wr;
   logic                       flag_rise;
   logic [`PBK_IRQ_WIDTH-1:0]  irq_set;
   logic [`PBK_IRQ_WIDTH-1:0]  irq_clr;
   logic [7:0]                 nxt_rdata;
   logic [7:0]                 data_view;

   // write strobes decoded per register
   logic wr_data, wr_dir, wr_pull, wr_slew, wr_drive;
   logic wr_stsctl, wr_srcsel, wr_polsel, wr_irq_clr, wr_irq_en;

   // *****************************************************************
   // write decode
   // *****************************************************************
   // one strobe per writable register
   assign wr_data    = reg_wr && (reg_addr == `PBK_ADDR_DATA);
   assign wr_dir     = reg_wr && (reg_addr == `PBK_ADDR_DIR);
   assign wr_pull    = reg_wr && (reg_addr == `PBK_ADDR_PULL);
   assign wr_slew    = reg_wr && (reg_addr == `PBK_ADDR_SLEW);
   assign wr_drive   = reg_wr && (reg_addr == `PBK_ADDR_DRIVE);
   assign wr_stsctl  = reg_wr && (reg_addr == `PBK_ADDR_STSCTL);
   assign wr_srcsel  = reg_wr && (reg_addr == `PBK_ADDR_SRCSEL);
   assign wr_polsel  = reg_wr && (reg_addr == `PBK_ADDR_POLSEL);
   assign wr_irq_clr = reg_wr && (reg_addr == `PBK_ADDR_IRQ_CLR);
   assign wr_irq_en  = reg_wr && (reg_addr == `PBK_ADDR_IRQ_EN);

   // acknowledge only on a one in its bit position
   assign ack_wr = wr_stsctl && reg_wdata[`PBK_SC_ACK_BIT]; // see R6

   // *****************************************************************
   // port data, direction and pull registers
   // *****************************************************************
   // data latch, all writes latched regardless of direction
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         port_data_latch_ff <= PINS'(`PBK_RST_DATA); // see R16
      end else if (wr_data) begin
         port_data_latch_ff <= reg_wdata[PINS-1:0];
      end
   end

   // direction, zero after reset leaves every pin an input
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         port_direction_ff <= PINS'(`PBK_RST_DIR); // see R16
      end else if (wr_dir) begin
         port_direction_ff <= reg_wdata[PINS-1:0];
      end
   end

   // pull enable, off after reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pull_device_enable_ff <= PINS'(`PBK_RST_PULL); // see R16
      end else if (wr_pull) begin
         pull_device_enable_ff <= reg_wdata[PINS-1:0];
      end
   end

   // *****************************************************************
   // output slew and drive registers
   // *****************************************************************
   // slew default is not trusted by software, it rewrites it
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         slew_limit_enable_ff <= PINS'(`PBK_RST_SLEW); // see R2
      end else if (wr_slew) begin
         slew_limit_enable_ff <= reg_wdata[PINS-1:0];
      end
   end

   // drive strength selection
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         drive_strength_select_ff <= PINS'(`PBK_RST_DRIVE);
      end else if (wr_drive) begin
         drive_strength_select_ff <= reg_wdata[PINS-1:0];
      end
   end

   // *****************************************************************
   // pin interrupt configuration
   // *****************************************************************
   // source select per pin
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pin_irq_source_select_ff <= PINS'(`PBK_RST_SRCSEL);
      end else if (wr_srcsel) begin
         pin_irq_source_select_ff <= reg_wdata[PINS-1:0];
      end
   end

   // polarity per pin, also picks pull direction
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pin_irq_polarity_select_ff <= PINS'(`PBK_RST_POLSEL);
      end else if (wr_polsel) begin
         pin_irq_polarity_select_ff <= reg_wdata[PINS-1:0]; // see R13
      end
   end

   // request enable and detection mode bits
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pin_irq_request_enable_ff <= 1'b0;
         detect_mode_select_ff     <= pbk_pkg::PBK_MODE_EDGE;
      end else if (wr_stsctl) begin
         pin_irq_request_enable_ff <= reg_wdata[`PBK_SC_IE_BIT];
         detect_mode_select_ff     <=
            pbk_pkg::pbk_mode_t'(reg_wdata[`PBK_SC_MODE_BIT]);
      end
   end

   // *****************************************************************
   // pin event detection
   // *****************************************************************
   // a pin is active when it sits at its selected polarity
   assign pin_active = pin_in ~^ pin_irq_polarity_select_ff; // see R11, R12

   // transition into the active state is the edge
   assign pin_edge = pin_active & ~active_prev_ff;

   // edges always count, sustained levels only in level mode
   always_comb begin
      if (detect_mode_select_ff == pbk_pkg::PBK_MODE_EDGE_LEVEL) begin
         pin_hit = pin_edge | pin_active; // see R9
      end else begin
         pin_hit = pin_edge; // see R9
      end
   end

   // unselected pins never contribute
   assign pin_event = |(pin_hit & pin_irq_source_select_ff); // see R10

   // previous active state for edge finding
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         active_prev_ff <= '0;
      end else begin
         active_prev_ff <= pin_active;
      end
   end

   // *****************************************************************
   // pin interrupt flag
   // *****************************************************************
   // set by detection, cleared by acknowledge, set wins over clear
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pin_irq_flag_ff <= 1'b0;
      end else if (pin_event) begin
         pin_irq_flag_ff <= 1'b1; // see R4
      end else if (ack_wr) begin
         pin_irq_flag_ff <= 1'b0; // see R6, R5
      end
   end

   // request to the processor
   assign pin_irq_req = pin_irq_flag_ff &&
                        pin_irq_request_enable_ff; // see R8, R18

   // *****************************************************************
   // block interrupt status, clear and enable
   // *****************************************************************
   // event: the pin flag is clear and gets set at the next clock edge
   assign flag_rise = pin_event && !pin_irq_flag_ff;

   assign irq_set = `PBK_IRQ_WIDTH'(flag_rise) << `PBK_IRQ_FLAG_SET_BIT;
   assign irq_clr = wr_irq_clr ? reg_wdata[`PBK_IRQ_WIDTH-1:0] : '0;

   // sticky status, a new event wins over a clear in the same cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_sts_ff <= '0;
      end else begin
         irq_sts_ff <= (irq_sts_ff & ~irq_clr) | irq_set;
      end
   end

   // interrupt enable mask
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_en_ff <= '0;
      end else if (wr_irq_en) begin
         irq_en_ff <= reg_wdata[`PBK_IRQ_WIDTH-1:0];
      end
   end

   // level interrupt while any enabled status bit is set
   assign irq = |(irq_sts_ff & irq_en_ff);

   // *****************************************************************
   // pin drivers and pad controls
   // *****************************************************************
   // output driver follows direction
   assign pin_out = port_data_latch_ff;
   assign pin_oe  = port_direction_ff; // see R15

   // pulls only on inputs, direction from polarity
   assign pull_up_en   = pull_device_enable_ff & ~port_direction_ff &
                         ~pin_irq_polarity_select_ff; // see R11, R17
   assign pull_down_en = pull_device_enable_ff & ~port_direction_ff &
                         pin_irq_polarity_select_ff; // see R12, R17

   // slew and drive act on outputs only
   assign slew_limit_on = slew_limit_enable_ff & port_direction_ff; // see R1
   assign drive_high_on = drive_strength_select_ff &
                          port_direction_ff; // see R3

   // *****************************************************************
   // read path
   // *****************************************************************
   // data read: pin for inputs, latch for outputs
   assign data_view = 8'(( pin_in & ~port_direction_ff) |
                         (port_data_latch_ff & port_direction_ff)); // see R14

   // read mux, unmapped addresses read zero
   always_comb begin
      nxt_rdata = `PBK_RST_BYTE;
      if (reg_addr == `PBK_ADDR_DATA) begin
         nxt_rdata = data_view;
      end else if (reg_addr == `PBK_ADDR_DIR) begin
         nxt_rdata = 8'(port_direction_ff);
      end else if (reg_addr == `PBK_ADDR_PULL) begin
         nxt_rdata = 8'(pull_device_enable_ff);
      end else if (reg_addr == `PBK_ADDR_SLEW) begin
         nxt_rdata = 8'(slew_limit_enable_ff);
      end else if (reg_addr == `PBK_ADDR_DRIVE) begin
         nxt_rdata = 8'(drive_strength_select_ff);
      end else if (reg_addr == `PBK_ADDR_STSCTL) begin
         // acknowledge bit left at zero
         nxt_rdata[`PBK_SC_FLAG_BIT] = pin_irq_flag_ff; // see R4, R7
         nxt_rdata[`PBK_SC_IE_BIT]   = pin_irq_request_enable_ff;
         nxt_rdata[`PBK_SC_MODE_BIT] = detect_mode_select_ff;
      end else if (reg_addr == `PBK_ADDR_SRCSEL) begin
         nxt_rdata = 8'(pin_irq_source_select_ff);
      end else if (reg_addr == `PBK_ADDR_POLSEL) begin
         nxt_rdata = 8'(pin_irq_polarity_select_ff);
      end else if (reg_addr == `PBK_ADDR_IRQ_STS) begin
         nxt_rdata = 8'(irq_sts_ff);
      end else if (reg_addr == `PBK_ADDR_IRQ_EN) begin
         nxt_rdata = 8'(irq_en_ff);
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_rdata_ff <= `PBK_RST_BYTE;
      end else if (reg_rd) begin
         reg_rdata_ff <= nxt_rdata;
      end else begin
         reg_rdata_ff <= `PBK_RST_BYTE;
      end
   end

   assign reg_rdata = reg_rdata_ff;

endmodule : pbk_port
`default_nettype wire

// file: test/pbk_port_monitor.sv
// assertion checker for the port block
`timescale 1ns/1ps
`default_nettype none
`include "pbk_regs.svh"

module pbk_port_monitor #(
   parameter int PINS = 8
) (
   input wire logic            ref_clk,
   input wire logic            rst,
   input wire logic [3:0]      reg_addr,
   input wire logic [7:0]      reg_wdata,
   input wire logic            reg_wr,
   input wire logic            reg_rd,
   input wire logic [7:0]      reg_rdata,
   input wire logic [PINS-1:0] pin_in,
   input wire logic [PINS-1:0] pin_out,
   input wire logic [PINS-1:0] pin_oe,
   input wire logic [PINS-1:0] pull_up_en,
   input wire logic [PINS-1:0] pull_down_en,
   input wire logic [PINS-1:0] slew_limit_on,
   input wire logic [PINS-1:0] drive_high_on,
   input wire logic            pin_irq_req,
   input wire logic            irq
);
   // ****
   // properties
   // ****
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_slew; (slew_limit_on & ~pin_oe) == '0; endproperty
   property p_drive; (drive_high_on & ~pin_oe) == '0; endproperty
   property p_pull_out; ((pull_up_en | pull_down_en) & pin_oe) == '0;
   endproperty
   property p_pull_one; (pull_up_en & pull_down_en) == '0; endproperty
   property p_ack_zero; $past(reg_rd && reg_addr == `PBK_ADDR_STSCTL)
      |-> reg_rdata[2] == 1'b0; endproperty
   property p_req; $past(reg_rd && reg_addr == `PBK_ADDR_STSCTL)
      |-> (reg_rdata[3] & reg_rdata[1]) == $past(pin_irq_req); endproperty
   property p_flag_hold; reg_wr && reg_addr == `PBK_ADDR_STSCTL
      && reg_wdata[2:1] == 2'b01 && pin_irq_req |=> pin_irq_req;
   endproperty
   property p_rst_state; $fell(rst) |-> pin_oe == '0 && pin_out == '0
      && pull_up_en == '0 && pull_down_en == '0 && !pin_irq_req;
   endproperty
   property p_data; $past(reg_rd && reg_addr == `PBK_ADDR_DATA)
      |-> reg_rdata[PINS-1:0] == (($past(pin_out) & $past(pin_oe))
      | ($past(pin_in) & ~$past(pin_oe))); endproperty

   a_slew: assert property (p_slew) else $error("slew on input");
   a_drive: assert property (p_drive) else $error("drive on input");
   a_pull_out: assert property (p_pull_out)
      else $error("pull on output");
   a_pull_one: assert property (p_pull_one)
      else $error("both pulls on");
   a_ack_zero: assert property (p_ack_zero)
      else $error("ack bit read one");
   a_req: assert property (p_req)
      else $error("request not flag and enable");
   a_flag_hold: assert property (p_flag_hold)
      else $error("flag lost without ack");
   a_rst_state: assert property (p_rst_state)
      else $error("state after reset");
   a_data: assert property (p_data)
      else $error("data read mixes wrong");

   c_req: cover property ($rose(pin_irq_req));
   c_irq: cover property ($rose(irq));
   c_pull: cover property (pull_up_en != '0 && pull_down_en != '0);
endmodule : pbk_port_monitor

bind pbk_port pbk_port_monitor #(.PINS(PINS)) pbk_port_monitor_i (
   .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
   .pin_oe(pin_oe), .pull_up_en(pull_up_en),
   .pull_down_en(pull_down_en), .slew_limit_on(slew_limit_on),
   .drive_high_on(drive_high_on), .pin_irq_req(pin_irq_req), .irq(irq));
`default_nettype wire

// file: test/pbk_pins_model.sv
// board model of the eight port pins
`timescale 1ns/1ps
`default_nettype none

module pbk_pins_model (
   input wire logic  ref_clk,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pull_up_en,
   input wire logic [7:0] pull_down_en,
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   output logic [7:0]     pin_in
);
   // driver wins, then board, then pulls; a floating pin wanders
   always_ff @(posedge ref_clk) begin
      pin_in <= (pin_oe & pin_out)
         | (~pin_oe & ext_en & ext_val)
         | (~pin_oe & ~ext_en & (pull_up_en
         | (~pull_down_en & ~pin_in)));
   end
endmodule : pbk_pins_model
`default_nettype wire

// file: test/pbk_port_bench.sv
// self-checking bench of the port block
`timescale 1ns/1ps
`default_nettype none
`include "pbk_regs.svh"

module pbk_port_bench;
   logic               ref_clk, rst, reg_wr, reg_rd, pin_irq_req, irq;
   pbk_pkg::pbk_addr_t reg_addr;
   pbk_pkg::pbk_byte_t reg_wdata;
   logic [7:0]         reg_rdata, pin_in, pin_out, pin_oe, ext_val, ext_en;
   logic [7:0]         pull_up_en, pull_down_en, slew_on, drive_on;
   int                 mismatches = 0;
   int                 n_tests = 0;

   pbk_port pbk_port_i (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pull_up_en(pull_up_en),
      .pull_down_en(pull_down_en), .slew_limit_on(slew_on),
      .drive_high_on(drive_on), .pin_irq_req(pin_irq_req), .irq(irq));
   pbk_pins_model pbk_pins_model_i (.ref_clk(ref_clk), .pin_out(pin_out),
      .pin_oe(pin_oe), .pull_up_en(pull_up_en),
      .pull_down_en(pull_down_en), .ext_val(ext_val), .ext_en(ext_en),
      .pin_in(pin_in));

   // ****
   // tasks
   // ****
   task automatic chk(input string name, input logic [7:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s exp %h got %h", name, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1; // let the written register settle before any compare
   endtask : wr

   task automatic rd(input string name, input logic [3:0] a, logic [7:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(name, e, reg_rdata);
   endtask : rd

   task automatic drive(input logic [7:0] v, input logic [7:0] e);
      @(posedge ref_clk);
      ext_val <= v;
      ext_en <= e;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask : drive

   task automatic tally_and_finish;
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   // clock and watchdog
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      tally_and_finish();
   end

   // main sequence
   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      ext_val = 8'h00;
      ext_en = 8'hFF;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      for (int a = 0; a < 12; a++)
         rd("reset", 4'(a), 8'h00);
      chk("oe_rst", 8'h00, pin_oe);
      wr(`PBK_ADDR_SLEW, 8'hFF);
      wr(`PBK_ADDR_DRIVE, 8'hFF);
      wr(`PBK_ADDR_DIR, 8'hF0);
      wr(`PBK_ADDR_DATA, 8'hA5);
      drive(8'h3C, 8'hFF);
      rd("slew", `PBK_ADDR_SLEW, 8'hFF);
      rd("data", `PBK_ADDR_DATA, 8'hAC);
      chk("oe", 8'hF0, pin_oe);
      chk("out", 8'hA5, pin_out);
      chk("slew_on", 8'hF0, slew_on);
      chk("drive_on", 8'hF0, drive_on);
      wr(`PBK_ADDR_PULL, 8'hFF);
      wr(`PBK_ADDR_POLSEL, 8'h05);
      chk("pull_up", 8'h0A, pull_up_en);
      chk("pull_dn", 8'h05, pull_down_en);
      drive(8'h00, 8'hF0);
      rd("pulled", `PBK_ADDR_DATA, 8'hAA);
      drive(8'h00, 8'hFF);
      wr(`PBK_ADDR_DIR, 8'h00);
      wr(`PBK_ADDR_PULL, 8'h00);
      wr(`PBK_ADDR_POLSEL, 8'h01);
      wr(`PBK_ADDR_SRCSEL, 8'h01);
      wr(`PBK_ADDR_IRQ_EN, 8'h01);
      wr(`PBK_ADDR_STSCTL, 8'h02);
      drive(8'h02, 8'hFF);
      rd("unselected", `PBK_ADDR_STSCTL, 8'h02);
      drive(8'h03, 8'hFF);
      chk("req", 8'h01, {7'h00, pin_irq_req});
      chk("irq", 8'h01, {7'h00, irq});
      rd("flag", `PBK_ADDR_STSCTL, 8'h0A);
      rd("irq_sts", `PBK_ADDR_IRQ_STS, 8'h01);
      wr(`PBK_ADDR_STSCTL, 8'h0A);
      rd("flag_kept", `PBK_ADDR_STSCTL, 8'h0A);
      wr(`PBK_ADDR_STSCTL, 8'h00);
      chk("req_off", 8'h00, {7'h00, pin_irq_req});
      wr(`PBK_ADDR_IRQ_EN, 8'h00);
      chk("irq_off", 8'h00, {7'h00, irq});
      wr(`PBK_ADDR_IRQ_CLR, 8'h01);
      rd("irq_clr", `PBK_ADDR_IRQ_STS, 8'h00);
      wr(`PBK_ADDR_STSCTL, 8'h06);
      rd("ack", `PBK_ADDR_STSCTL, 8'h02);
      wr(`PBK_ADDR_STSCTL, 8'h0A);
      rd("flag_wr", `PBK_ADDR_STSCTL, 8'h02);
      wr(`PBK_ADDR_STSCTL, 8'h03);
      rd("level", `PBK_ADDR_STSCTL, 8'h0B);
      wr(`PBK_ADDR_STSCTL, 8'h07);
      rd("level_ack", `PBK_ADDR_STSCTL, 8'h0B);
      wr(`PBK_ADDR_STSCTL, 8'h02);
      wr(`PBK_ADDR_POLSEL, 8'h00);
      wr(`PBK_ADDR_STSCTL, 8'h06);
      rd("fall_idle", `PBK_ADDR_STSCTL, 8'h02);
      drive(8'h02, 8'hFF);
      rd("fall", `PBK_ADDR_STSCTL, 8'h0A);
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      rd("rerst", `PBK_ADDR_STSCTL, 8'h00);
      chk("req_rst", 8'h00, {7'h00, pin_irq_req});
      tally_and_finish();
   end
endmodule : pbk_port_bench
`default_nettype wire
